// >>> include/lcdmx_pkg.sv
package lcdmx_pkg;

  // Timing
  localparam int SYS_CLK_HZ    = 50_000_000;
  localparam int OSC_DIV       = 64;
  localparam int FCLK_SLOW_HZ  = 3600;
  localparam int FCLK_FAST_HZ  = 5280;
  localparam int OSC_CYC_SLOW  = SYS_CLK_HZ / (FCLK_SLOW_HZ * OSC_DIV);
  localparam int OSC_CYC_FAST  = SYS_CLK_HZ / (FCLK_FAST_HZ * OSC_DIV);
  localparam int FRAME_PERIODS = 24;
  localparam int SLOT_LEN_STATIC = FRAME_PERIODS / 2;
  localparam int SLOT_LEN_MUX2   = FRAME_PERIODS / 4;
  localparam int SLOT_LEN_MUX3   = FRAME_PERIODS / 6;
  localparam int SLOT_LEN_MUX4   = FRAME_PERIODS / 8;
  localparam logic [4:0] FRAME_LAST    = 5'(FRAME_PERIODS - 1);
  localparam logic [5:0] OSC_DIV_LAST  = 6'(OSC_DIV - 1);

  // Sizes
  localparam int NUM_SEG = 80;
  localparam int NUM_BP  = 4;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [3:0] RAM_ROW_FIRST  = 4'h1;
  localparam logic [3:0] RAM_ROW_LAST   = 4'h4;
  localparam logic [1:0] RAM_WORD_LAST  = 2'h2;

  // Control fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_BIAS_BIT = 3;

  // Status fields
  localparam int ST_EXT_BIT   = 0;
  localparam int ST_BP_LSB    = 1;
  localparam int ST_PHASE_BIT = 3;
  localparam int ST_POS_LSB   = 4;
  localparam int ST_EN_BIT    = 9;
  localparam int ST_MODE_LSB  = 10;
  localparam int ST_BIAS_BIT  = 12;

  // Electrode levels, fractions of the LCD supply
  typedef logic [1:0] lcdmx_lvl_t;
  localparam lcdmx_lvl_t LVL_VSS  = 2'h0;
  localparam lcdmx_lvl_t LVL_V1   = 2'h1;
  localparam lcdmx_lvl_t LVL_V2   = 2'h2;
  localparam lcdmx_lvl_t LVL_VLCD = 2'h3;

  typedef enum logic [1:0] {MODE_STATIC, MODE_MUX2, MODE_MUX3, MODE_MUX4} lcdmx_mode_t;
  typedef enum logic {PH_DRIVE, PH_INVERT} lcdmx_phase_t;

  typedef struct packed {
    logic        en;
    lcdmx_mode_t mode;
    logic        half_bias;
  } lcdmx_cfg_t;

  localparam lcdmx_cfg_t CFG_RESET = '{en: 1'b0, mode: MODE_MUX4, half_bias: 1'b0};

  typedef logic [NUM_SEG-1:0]             lcdmx_row_t;
  typedef lcdmx_lvl_t [NUM_BP-1:0]        lcdmx_bp_t;
  typedef lcdmx_lvl_t [NUM_SEG-1:0]       lcdmx_seg_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } lcdmx_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } lcdmx_ahb_rsp_t;

endpackage

// >>> src/lcdmx_clkgen.sv
module lcdmx_clkgen (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Strap and clock pins
  input  wire logic osc_select,
  input  wire logic frame_rate_select,
  input  wire logic clk_pin_i,
  output logic      clk_pin_o,
  output logic      clk_pin_oe,
  // Timing clock
  output logic      clk_en,
  output logic      ext_mode
);
  localparam int PIN_OSC = 0;
  localparam int PIN_RATE = 1;
  localparam int PIN_CLK = 2;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] st;
    logic [7:0] osc_cnt;
    logic [5:0] div;
    logic       en;
    logic       clk_out;
    logic       oe;
    logic [1:0] warm;
  } lcdmx_cg_state_t;

  lcdmx_cg_state_t q;
  lcdmx_cg_state_t d;
  logic [7:0]      osc_last;

  always_comb
  begin
    d = q;
    d.s1 = {clk_pin_i, frame_rate_select, osc_select};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 3; i++)
    begin
      if (q.s2[i] == q.s3[i])
      begin
        d.st[i] = q.s3[i];
      end
    end
    osc_last = q.st[PIN_RATE] ? 8'(lcdmx_pkg::OSC_CYC_SLOW - 1)
                            : 8'(lcdmx_pkg::OSC_CYC_FAST - 1); // see RQ7
    d.en = 1'b0;
    if (q.warm != 2'h3)
    begin
      d.warm = q.warm + 2'h1;
    end
    if (q.st[PIN_OSC])
    begin
      d.oe      = 1'b0; // see RQ4
      d.osc_cnt = 8'h00;
      d.div     = 6'h00;
      d.clk_out = 1'b0;
      d.en      = d.st[PIN_CLK] && !q.st[PIN_CLK]; // see RQ2
    end
    else
    begin
      // Stay off the pin until the select strap has settled
      d.oe = (q.warm == 2'h3) && !d.st[PIN_OSC]; // see RQ3
      // Compare with >= so a rate change mid-count cannot overrun
      if (q.osc_cnt >= osc_last)
      begin
        d.osc_cnt = 8'h00;
        d.div     = q.div + 6'h01;
        d.en      = (q.div == lcdmx_pkg::OSC_DIV_LAST); // see RQ1
      end
      else
      begin
        d.osc_cnt = q.osc_cnt + 8'h01;
      end
      d.clk_out = d.div[5];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  assign clk_en     = q.en;
  assign ext_mode   = q.st[PIN_OSC];
  assign clk_pin_o  = q.clk_out;
  assign clk_pin_oe = q.oe;

  // Cycles between two enables, only trusted over a quiet interval
  logic [15:0] gap_q;
  logic        gap_ok_q;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap_q    <= 16'h0000;
      gap_ok_q <= 1'b0;
    end
    else if (q.st[PIN_OSC] || (q.st[PIN_RATE] != d.st[PIN_RATE]))
    begin
      gap_q    <= 16'h0000;
      gap_ok_q <= 1'b0;
    end
    else if (q.en)
    begin
      gap_q    <= 16'h0000;
      gap_ok_q <= 1'b1;
    end
    else
    begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_osc_div_64: assert property ( // see RQ1
    (q.en && gap_ok_q && !q.st[PIN_OSC] && $stable(q.st[PIN_RATE])) |->
      (gap_q == 16'(64 * (q.st[PIN_RATE] ? lcdmx_pkg::OSC_CYC_SLOW
                                         : lcdmx_pkg::OSC_CYC_FAST) - 1)))
    else $error("Internal timing clock is not oscillator divided by 64");
  a_ext_no_div: assert property ( // see RQ2
    (q.st[PIN_OSC] && d.st[PIN_OSC] && d.st[PIN_CLK] && !q.st[PIN_CLK]) |=> clk_en)
    else $error("External clock edge did not give a timing pulse");
  a_clk_pin_dir: assert property ( // see RQ3
    $changed(q.st[PIN_OSC]) |=> (clk_pin_oe == !$past(q.st[PIN_OSC])))
    else $error("Clock pin direction does not follow the oscillator select");
endmodule

// >>> src/lcdmx_drive.sv
module lcdmx_drive (
  // Active configuration and sequence position
  input  lcdmx_pkg::lcdmx_cfg_t   cfg,
  input  wire logic [1:0]         bp_idx,
  input  lcdmx_pkg::lcdmx_phase_t phase,
  input  lcdmx_pkg::lcdmx_row_t   disp,
  // Electrode levels
  output lcdmx_pkg::lcdmx_bp_t    bp_lvl,
  output lcdmx_pkg::lcdmx_seg_t   seg_lvl
);
  logic inv;
  logic third;
  assign inv   = (phase == lcdmx_pkg::PH_INVERT);
  assign third = !cfg.half_bias && (cfg.mode != lcdmx_pkg::MODE_STATIC);

  // Which time slot a physical backplane answers to
  function automatic logic [1:0] bp_slot(input int j, input lcdmx_pkg::lcdmx_mode_t m);
    logic [1:0] jj;
    jj = 2'(j);
    case (m)
      lcdmx_pkg::MODE_STATIC: bp_slot = 2'h0;
      lcdmx_pkg::MODE_MUX2:   bp_slot = {1'b0, jj[0]};
      lcdmx_pkg::MODE_MUX3:   bp_slot = (jj == 2'h3) ? 2'h1 : jj; // see RQ21
      default:                bp_slot = jj;
    endcase
  endfunction

  for (genvar j = 0; j < lcdmx_pkg::NUM_BP; j++)
  begin : g_bp
    always_comb
    begin
      if (!cfg.en)
        bp_lvl[j] = lcdmx_pkg::LVL_VSS; // see RQ24
      else if (bp_slot(j, cfg.mode) == bp_idx)
        bp_lvl[j] = inv ? lcdmx_pkg::LVL_VSS : lcdmx_pkg::LVL_VLCD; // see RQ9, RQ12, RQ13
      else if (third)
        bp_lvl[j] = inv ? lcdmx_pkg::LVL_V2 : lcdmx_pkg::LVL_V1; // see RQ10
      else
        bp_lvl[j] = lcdmx_pkg::LVL_V1; // see RQ10, RQ14
    end
  end

  // Static and half bias share one segment pattern
  for (genvar s = 0; s < lcdmx_pkg::NUM_SEG; s++)
  begin : g_seg
    always_comb
    begin
      if (!cfg.en)
        seg_lvl[s] = lcdmx_pkg::LVL_VSS; // see RQ24
      else if (third)
        seg_lvl[s] = disp[s] ? (inv ? lcdmx_pkg::LVL_VLCD : lcdmx_pkg::LVL_VSS)
                             : (inv ? lcdmx_pkg::LVL_V1 : lcdmx_pkg::LVL_V2); // see RQ17, RQ20
      else
        seg_lvl[s] = (disp[s] ^ inv) ? lcdmx_pkg::LVL_VSS : lcdmx_pkg::LVL_VLCD; // see RQ17, RQ20
    end
  end
endmodule

// >>> src/lcdmx_top.sv
// Overview of operation
// RQ1 - Internal oscillator divided by 64 times everything
// RQ2 - External clock used undivided as timing clock
// RQ3 - Select low: oscillator on, clock pin drives
// RQ4 - Select high: clock pin is timing input
// RQ5 - System keeps a clock running at all times
// RQ6 - One frame per 24 timing clock periods
// RQ7 - Rate pin picks 3600 or 5280 Hz clock
// RQ8 - Levels follow the last loaded drive configuration
// RQ9 - Static mode: one backplane, two levels
// RQ10 - Two backplanes: half or third bias
// RQ11 - Half bias closes the divider bypass switch
// RQ12 - Three backplanes sequenced at third bias
// RQ13 - Four backplanes sequenced at third bias
// RQ14 - Half bias also allowed with three, four
// RQ15 - Frame timing moves RAM data to segments
// RQ16 - Display register steady during its backplane slot
// RQ17 - Segment level from phase and register bit
// RQ18 - Cascade link keeps all chips' frames aligned
// RQ19 - RAM row n pairs with backplane n
// RQ20 - One turns element on, zero leaves off
// RQ21 - Three backplanes: fourth copies the second
// RQ22 - Content shown only once enable is set
// RQ23 - Equal slots, each phase paired with inverse
// RQ24 - Disabled: all electrodes at zero voltage
module lcdmx_top (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // Register bus
  input  lcdmx_pkg::lcdmx_ahb_req_t ahb_req,
  output lcdmx_pkg::lcdmx_ahb_rsp_t ahb_rsp,
  // Strap pins
  input  wire logic                 osc_select,
  input  wire logic                 frame_rate_select,
  // Clock pin
  input  wire logic                 clk_pin_i,
  output logic                      clk_pin_o,
  output logic                      clk_pin_oe,
  // Cascade link, open drain
  input  wire logic                 sync_i,
  output logic                      sync_o,
  output logic                      sync_oe,
  // Panel
  output lcdmx_pkg::lcdmx_bp_t      backplane_outputs,
  output lcdmx_pkg::lcdmx_seg_t     segment_outputs,
  output logic                      bias_bypass
);

  typedef struct packed {
    lcdmx_pkg::lcdmx_cfg_t                          cfg_sh;
    lcdmx_pkg::lcdmx_cfg_t                          act;
    lcdmx_pkg::lcdmx_row_t [lcdmx_pkg::NUM_BP-1:0]  ram;
    lcdmx_pkg::lcdmx_row_t                          disp;
    logic [4:0]                                     pos;
    logic [3:0]                                     slot;
    logic [1:0]                                     bp;
    lcdmx_pkg::lcdmx_phase_t                        phase;
    logic [2:0]                                     sy;
    logic                                           sy_st;
    logic                                           sync_oe;
    logic                                           bypass;
    lcdmx_pkg::lcdmx_bp_t                           bp_out;
    lcdmx_pkg::lcdmx_seg_t                          seg_out;
    logic                                           wr_pend;
    logic [7:0]                                     addr;
    logic [31:0]                                    rdata;
    logic                                           ready;
  } lcdmx_state_t;

  lcdmx_state_t          q;
  lcdmx_state_t          d;
  logic                  clk_en;
  logic                  ext_mode;
  logic                  accept;
  logic                  sync_fall;
  logic                  realign;
  logic                  slot_load;
  lcdmx_pkg::lcdmx_bp_t  bp_w;
  lcdmx_pkg::lcdmx_seg_t seg_w;

  lcdmx_clkgen u_clkgen (
    .ref_clk           (ref_clk),
    .sys_rst           (sys_rst),
    .osc_select        (osc_select),
    .frame_rate_select (frame_rate_select),
    .clk_pin_i         (clk_pin_i),
    .clk_pin_o         (clk_pin_o),
    .clk_pin_oe        (clk_pin_oe),
    .clk_en            (clk_en),
    .ext_mode          (ext_mode)
  );

  lcdmx_drive u_drive (
    .cfg     (q.act),
    .bp_idx  (q.bp),
    .phase   (q.phase),
    .disp    (q.disp),
    .bp_lvl  (bp_w),
    .seg_lvl (seg_w)
  );

  function automatic logic [3:0] slot_last(input lcdmx_pkg::lcdmx_mode_t m);
    case (m)
      lcdmx_pkg::MODE_STATIC: slot_last = 4'(lcdmx_pkg::SLOT_LEN_STATIC - 1);
      lcdmx_pkg::MODE_MUX2:   slot_last = 4'(lcdmx_pkg::SLOT_LEN_MUX2 - 1);
      lcdmx_pkg::MODE_MUX3:   slot_last = 4'(lcdmx_pkg::SLOT_LEN_MUX3 - 1);
      default:                slot_last = 4'(lcdmx_pkg::SLOT_LEN_MUX4 - 1);
    endcase
  endfunction

  function automatic logic ram_hit(input logic [7:0] a);
    ram_hit = (a[7:4] >= lcdmx_pkg::RAM_ROW_FIRST) && (a[7:4] <= lcdmx_pkg::RAM_ROW_LAST)
              && (a[3:2] <= lcdmx_pkg::RAM_WORD_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [1:0] ram_row(input logic [7:0] a);
    ram_row = 2'(a[7:4] - lcdmx_pkg::RAM_ROW_FIRST);
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a, input lcdmx_state_t s,
                                           input logic ext);
    logic [31:0] v;
    lcdmx_pkg::lcdmx_row_t r;
    v = 32'h0000_0000;
    r = s.ram[ram_row(a)];
    if (a == lcdmx_pkg::REG_CTRL)
    begin
      v[lcdmx_pkg::CTRL_EN_BIT]                = s.cfg_sh.en;
      v[lcdmx_pkg::CTRL_MODE_LSB +: 2]         = s.cfg_sh.mode;
      v[lcdmx_pkg::CTRL_BIAS_BIT]              = s.cfg_sh.half_bias;
    end
    else if (a == lcdmx_pkg::REG_STATUS)
    begin
      v[lcdmx_pkg::ST_EXT_BIT]                 = ext;
      v[lcdmx_pkg::ST_BP_LSB +: 2]             = s.bp;
      v[lcdmx_pkg::ST_PHASE_BIT]               = (s.phase == lcdmx_pkg::PH_INVERT);
      v[lcdmx_pkg::ST_POS_LSB +: 5]            = s.pos;
      v[lcdmx_pkg::ST_EN_BIT]                  = s.act.en;
      v[lcdmx_pkg::ST_MODE_LSB +: 2]           = s.act.mode;
      v[lcdmx_pkg::ST_BIAS_BIT]                = s.act.half_bias;
    end
    else if (ram_hit(a))
    begin
      if (a[3:2] == 2'h0)
        v = r[31:0];
      else if (a[3:2] == 2'h1)
        v = r[63:32];
      else
        v[15:0] = r[79:64];
    end
    reg_read = v;
  endfunction

  always_comb
  begin
    d = q;

    // Register bus: writes land in the data phase
    if (q.wr_pend)
    begin
      if (q.addr == lcdmx_pkg::REG_CTRL)
      begin
        d.cfg_sh.en        = ahb_req.hwdata[lcdmx_pkg::CTRL_EN_BIT];
        d.cfg_sh.mode      = lcdmx_pkg::lcdmx_mode_t'(ahb_req.hwdata[lcdmx_pkg::CTRL_MODE_LSB +: 2]);
        d.cfg_sh.half_bias = ahb_req.hwdata[lcdmx_pkg::CTRL_BIAS_BIT];
      end
      else if (ram_hit(q.addr))
      begin
        if (q.addr[3:2] == 2'h0)
          d.ram[ram_row(q.addr)][31:0] = ahb_req.hwdata;
        else if (q.addr[3:2] == 2'h1)
          d.ram[ram_row(q.addr)][63:32] = ahb_req.hwdata;
        else
          d.ram[ram_row(q.addr)][79:64] = ahb_req.hwdata[15:0];
      end
    end
    accept    = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    d.ready   = 1'b1;
    d.wr_pend = accept && ahb_req.hwrite && (ahb_req.haddr[31:8] == 24'h000000);
    d.addr    = ahb_req.haddr[7:0];
    // Read from the next state so a write just before is seen
    if (accept && !ahb_req.hwrite && (ahb_req.haddr[31:8] == 24'h000000))
      d.rdata = reg_read(ahb_req.haddr[7:0], d, ext_mode);
    else
      d.rdata = 32'h0000_0000;

    // Cascade link input, settled when the last two stages agree
    d.sy = {q.sy[1:0], sync_i};
    if (q.sy[1] == q.sy[2])
      d.sy_st = q.sy[2];
    sync_fall = q.sy_st && (q.sy[1] == q.sy[2]) && !q.sy[2];
    realign   = sync_fall && (q.pos != 5'h00); // see RQ18

    // Frame sequencer
    slot_load = 1'b0;
    if (realign || (clk_en && (q.pos == lcdmx_pkg::FRAME_LAST))) // see RQ6
    begin
      d.pos     = 5'h00;
      d.slot    = 4'h0;
      d.bp      = 2'h0;
      d.phase   = lcdmx_pkg::PH_DRIVE;
      d.act     = q.cfg_sh; // see RQ8, RQ22
      slot_load = 1'b1;
    end
    else if (clk_en)
    begin
      d.pos = q.pos + 5'h01;
      if (q.slot == slot_last(q.act.mode))
      begin
        d.slot    = 4'h0;
        slot_load = 1'b1;
        if (q.bp == 2'(q.act.mode))
        begin
          // First half drives, second half repeats inverted
          d.bp    = 2'h0;
          d.phase = lcdmx_pkg::PH_INVERT; // see RQ23
        end
        else
        begin
          d.bp = q.bp + 2'h1;
        end
      end
      else
      begin
        d.slot = q.slot + 4'h1;
      end
    end
    // Row latched only at slot start, held for the whole slot
    if (slot_load)
      d.disp = q.ram[d.bp]; // see RQ15, RQ16, RQ19

    d.sync_oe = (q.pos == 5'h00); // see RQ18
    d.bypass  = q.act.half_bias && (q.act.mode != lcdmx_pkg::MODE_STATIC); // see RQ11, RQ14
    d.bp_out  = bp_w;
    d.seg_out = seg_w;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q        <= '0;
      q.cfg_sh <= lcdmx_pkg::CFG_RESET;
      q.act    <= lcdmx_pkg::CFG_RESET;
      q.sy     <= 3'h7;
      q.sy_st  <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign ahb_rsp.hreadyout = q.ready;
  assign ahb_rsp.hresp     = 1'b0;
  assign ahb_rsp.hrdata    = q.rdata;
  assign sync_o            = 1'b0;
  assign sync_oe           = q.sync_oe;
  assign bias_bypass       = q.bypass;
  assign backplane_outputs = q.bp_out;
  assign segment_outputs   = q.seg_out;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_frame_end;
    clk_en && !realign && (q.pos == lcdmx_pkg::FRAME_LAST);
  endsequence
  sequence s_frame_start;
    (q.pos == 5'h00) && (q.bp == 2'h0) && (q.phase == lcdmx_pkg::PH_DRIVE);
  endsequence

  a_frame_wrap: assert property (s_frame_end |=> s_frame_start) // see RQ6
    else $error("Frame did not restart after 24 periods");
  a_phase_half: assert property ( // see RQ23
    (q.pos == 5'd12) |-> (q.phase == lcdmx_pkg::PH_INVERT) && (q.bp == 2'h0) && (q.slot == 4'h0))
    else $error("Inverted half does not start mid frame");
  a_disp_stable: assert property (!slot_load |=> $stable(q.disp)) // see RQ16
    else $error("Display register changed inside a slot");
  a_disp_row: assert property (slot_load |=> (q.disp == $past(q.ram[d.bp]))) // see RQ19
    else $error("Display register not loaded from the slot's row");
  a_dark_off: assert property ( // see RQ24
    !q.act.en |=> (backplane_outputs == '0) && (segment_outputs == '0))
    else $error("Outputs not at zero while disabled");
  a_bp3_mirror: assert property ( // see RQ21
    (q.act.mode == lcdmx_pkg::MODE_MUX3) |=> (backplane_outputs[3] == backplane_outputs[1]))
    else $error("Fourth backplane differs from second in three-way mode");
  a_mux3_active: assert property ( // see RQ12
    (q.act.en && (q.act.mode == lcdmx_pkg::MODE_MUX3) && (q.bp == 2'h2)
      && (q.phase == lcdmx_pkg::PH_DRIVE)) |=> (backplane_outputs[2] == lcdmx_pkg::LVL_VLCD))
    else $error("Third backplane not active in its slot");
  a_seg_on_third: assert property ( // see RQ20
    (q.act.en && !q.act.half_bias && (q.act.mode != lcdmx_pkg::MODE_STATIC)
      && (q.phase == lcdmx_pkg::PH_DRIVE) && q.disp[0]) |=> (segment_outputs[0] == lcdmx_pkg::LVL_VSS))
    else $error("Segment for a set bit not at the on level");
  a_bypass_half: assert property ( // see RQ11
    (q.act.half_bias && (q.act.mode == lcdmx_pkg::MODE_MUX2)) |=> bias_bypass)
    else $error("Bias bypass open in half bias two-way mode");
  a_sync_drive: assert property ((s_frame_end ##1 1'b1) |=> sync_oe) // see RQ18
    else $error("Cascade link not pulled at frame start");
endmodule

// >>> test/lcdmx_partner.sv
module lcdmx_partner (
  // Clock
  input  wire logic ref_clk,
  // Device pins
  input  wire logic clk_pin_o,
  input  wire logic clk_pin_oe,
  input  wire logic sync_oe,
  // Bench command
  input  wire logic pull_req,
  // Resolved wires
  output logic      clk_pin_i,
  output logic      sync_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ext_clk = 1'b0;
  logic pull    = 1'b0;
  // Free running, never stopped
  initial forever #400 ext_clk = ~ext_clk;
  assign clk_pin_i = clk_pin_oe ? clk_pin_o : ext_clk;
  // Pull-up, low if any chip pulls
  assign sync_i = ~(sync_oe | pull);
  // Companion pulls at its own period start, out of step with the device
  always @(posedge pull_req)
  begin
    @(posedge ext_clk);
    // A real companion pulls some cycles after its clock edge
    repeat (6) @(posedge ref_clk);
    pull <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pull <= 1'b0;
  end
endmodule

// >>> test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      ref_clk = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      osc_select = 1'b0;
  logic                      frame_rate_select = 1'b0;
  logic                      pull_req = 1'b0;
  logic                      rd_pend = 1'b0;
  logic                      clk_pin_i, clk_pin_o, clk_pin_oe;
  logic                      sync_i, sync_o, sync_oe, bias_bypass;
  lcdmx_pkg::lcdmx_ahb_req_t req_v = '0;
  lcdmx_pkg::lcdmx_ahb_req_t ahb_req;
  lcdmx_pkg::lcdmx_ahb_rsp_t ahb_rsp;
  lcdmx_pkg::lcdmx_bp_t      bp;
  lcdmx_pkg::lcdmx_seg_t     seg;
  logic [31:0]               exp_q[$];
  logic [31:0]               rnd = 32'h0000006F;
  int                        fails = 0;
  int                        num_checks = 0;
  int                        cyc = 0;
  int                        t;

  initial forever #10 ref_clk = ~ref_clk;
  always_comb
  begin
    ahb_req = req_v;
    ahb_req.hready = ahb_rsp.hreadyout;
  end

  lcdmx_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .osc_select(osc_select), .frame_rate_select(frame_rate_select), .clk_pin_i(clk_pin_i),
    .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe), .sync_i(sync_i), .sync_o(sync_o),
    .sync_oe(sync_oe), .backplane_outputs(bp), .segment_outputs(seg), .bias_bypass(bias_bypass));
  lcdmx_partner partner (.ref_clk(ref_clk), .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe),
    .sync_oe(sync_oe), .pull_req(pull_req), .clk_pin_i(clk_pin_i), .sync_i(sync_i));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Single transfer, holds each phase until hready is sampled high
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req_v <= '{hsel: 1'b1, haddr: a, htrans: 2'h2, hwrite: wr, hsize: 3'h2, hready: 1'b0,
               hwdata: req_v.hwdata};
    do @(posedge ref_clk); while (ahb_rsp.hreadyout !== 1'b1);
    req_v.htrans <= 2'h0;
    req_v.hsel <= 1'b0;
    req_v.hwdata <= d;
    rd_pend <= ~wr;
    do @(posedge ref_clk); while (ahb_rsp.hreadyout !== 1'b1);
    rd_pend <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h00000000);
  endtask

  always @(posedge ref_clk)
    if (rd_pend === 1'b1 && ahb_rsp.hreadyout === 1'b1)
      chk("hrdata", exp_q.pop_front(), ahb_rsp.hrdata);

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      fails++;
      finish_test();
    end
  end

  // Cycles up to the next rise of clk_pin_o (sel 0) or sync_oe (sel 1)
  task automatic rise(input int sel, output int n);
    logic prev;
    n = 0;
    do
    begin
      prev = sel ? sync_oe : clk_pin_o;
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (!((sel ? sync_oe : clk_pin_o) === 1'b1 && prev === 1'b0));
  endtask

  // Expected levels in backplane slot 0; row 0 holds seg 0 on, seg 1 off
  task automatic panel(input lcdmx_pkg::lcdmx_mode_t m, input logic h, input logic inv);
    logic                 lo;
    lcdmx_pkg::lcdmx_bp_t eb;
    lo = h || m == lcdmx_pkg::MODE_STATIC;
    for (int i = 0; i < 4; i++)
      eb[i] = (i == 0 || m == lcdmx_pkg::MODE_STATIC || (m == lcdmx_pkg::MODE_MUX2 && i == 2))
        ? (inv ? 2'h0 : 2'h3) : ((inv && !lo) ? 2'h2 : 2'h1);
    chk("backplanes", 32'(eb), 32'(bp));
    chk("seg on", inv ? 32'h3 : 32'h0, 32'(seg[0]));
    chk("seg off", 32'(lo ? (inv ? 2'h0 : 2'h3) : (inv ? 2'h1 : 2'h2)), 32'(seg[1]));
    chk("bypass", 32'(h && m != lcdmx_pkg::MODE_STATIC), 32'(bias_bypass));
  endtask

  task automatic run_mode(input lcdmx_pkg::lcdmx_mode_t m, input logic h);
    int n;
    xfer(1'b1, 32'(lcdmx_pkg::REG_CTRL), 32'({h, m, 1'b1}));
    rise(1, n);
    rise(1, n);
    chk("frame length", 32'(lcdmx_pkg::FRAME_PERIODS * 40), 32'(n));
    repeat (60) @(posedge ref_clk);
    panel(m, h, 1'b0);
    repeat (480) @(posedge ref_clk);
    panel(m, h, 1'b1);
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("bp off", 32'h0, 32'(bp));
    chk("seg off", 32'h0, 32'(|seg));
    rd(32'(lcdmx_pkg::REG_CTRL), 32'({lcdmx_pkg::CFG_RESET.half_bias, lcdmx_pkg::CFG_RESET.mode,
       lcdmx_pkg::CFG_RESET.en}));
    chk("clk drive", 32'h1, 32'(clk_pin_oe));
    rise(0, t);
    rise(0, t);
    chk("fast period", 32'(lcdmx_pkg::OSC_DIV * lcdmx_pkg::OSC_CYC_FAST), 32'(t));
    frame_rate_select <= 1'b1;
    rise(0, t);
    rise(0, t);
    rise(0, t);
    chk("slow period", 32'(lcdmx_pkg::OSC_DIV * lcdmx_pkg::OSC_CYC_SLOW), 32'(t));
    $display("Internal clock test done");
    sys_rst <= 1'b1;
    osc_select <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("clk input", 32'h0, 32'(clk_pin_oe));
    for (int r = 0; r < 4; r++)
      for (int w = 0; w < 3; w++)
      begin
        rnd = lfsr(rnd);
        xfer(1'b1, 32'h10 + 32'(r * 16 + w * 4), rnd);
        rd(32'h10 + 32'(r * 16 + w * 4), w == 2 ? rnd & 32'h0000FFFF : rnd);
      end
    xfer(1'b1, 32'h10, 32'h00000001);
    xfer(1'b1, 32'h14, 32'h00000000);
    xfer(1'b1, 32'h18, 32'h00000000);
    rd(32'h00000100, 32'h00000000);
    $display("Register test done");
    for (int k = 0; k < 8; k++)
      run_mode(lcdmx_pkg::lcdmx_mode_t'(k[1:0]), k[2]);
    $display("Drive mode test done");
    rise(1, t);
    repeat (300) @(posedge ref_clk);
    pull_req <= 1'b1;
    @(negedge sync_i);
    pull_req <= 1'b0;
    repeat (10) @(posedge ref_clk);
    // External clock, position 0, enabled 1:4 half bias
    rd(32'(lcdmx_pkg::REG_STATUS), 32'h00001E01);
    xfer(1'b1, 32'(lcdmx_pkg::REG_CTRL), 32'h00000006);
    rise(1, t);
    rise(1, t);
    repeat (60) @(posedge ref_clk);
    chk("bp disabled", 32'h0, 32'(bp));
    chk("seg disabled", 32'h0, 32'(|seg));
    $display("Cascade and disable test done");
    finish_test();
  end
endmodule
